// ==== src/tbuc_pkg.sv ====
// Constants, register map and state type for the torque bias block
package tbuc_pkg;
    // Clock and control tick
    localparam int CLK_MHZ = 200;
    localparam int TICK_MS = 10;
    localparam int TICK_CYCLES = TICK_MS * 1000 * CLK_MHZ;
    // Percent scale, 0.1 % per unit
    localparam int PCT_FULL = 1000;
    localparam int PCT_MAX = 2000;
    localparam int PGAIN_ONE = 100;
    // Terminal function codes
    localparam logic [7:0] FN_SEL_A = 8'h3c;
    localparam logic [7:0] FN_SEL_B = 8'h3d;
    localparam logic [7:0] FN_HOLD = 8'h3e;
    localparam logic [7:0] FN_UNBALANCE_START_CMD = 8'h43;
    // Bias source codes
    localparam logic [1:0] SRC_ANALOG = 2'h0;
    localparam logic [1:0] SRC_DIGITAL = 2'h1;
    localparam logic [1:0] SRC_PI = 2'h2;
    // Register word addresses
    localparam logic [4:0] A_CTRL = 5'h00;
    localparam logic [4:0] A_START = 5'h01;
    localparam logic [4:0] A_END = 5'h02;
    localparam logic [4:0] A_LIMIT = 5'h03;
    localparam logic [4:0] A_PGAIN = 5'h04;
    localparam logic [4:0] A_ITIME = 5'h05;
    localparam logic [4:0] A_DGAIN = 5'h06;
    localparam logic [4:0] A_BGAIN = 5'h07;
    localparam logic [4:0] A_DIG1 = 5'h08;
    localparam logic [4:0] A_DIG2 = 5'h09;
    localparam logic [4:0] A_DIG3 = 5'h0a;
    localparam logic [4:0] A_EST = 5'h0b;
    localparam logic [4:0] A_HOLD = 5'h0c;
    localparam logic [4:0] A_STATUS = 5'h0d;
    localparam logic [4:0] A_BIAS = 5'h0e;
    localparam logic [4:0] A_COMP = 5'h0f;
    localparam logic [4:0] A_TERM = 5'h10;
    // Control register fields
    localparam int CTRL_UC_BIT = 0;
    localparam int CTRL_TQ_BIT = 1;
    localparam int CTRL_SRC_LSB = 2;
    // Reset values
    localparam logic [15:0] RST_LIMIT = 16'h07d0;
    localparam logic [15:0] RST_PGAIN = 16'h0064;
    localparam logic [15:0] RST_GAIN = 16'h03e8;
    localparam logic [15:0] RST_EST = 16'h000a;
    localparam logic [15:0] RST_HOLD = 16'h0014;
    // Unbalance compensation sequence
    typedef enum logic [2:0] {UC_IDLE, UC_WAIT, UC_EST, UC_COMP, UC_DECAY, UC_OFF} tbuc_state_type;
endpackage

// ==== src/tbuc_top.sv ====
// Torque bias sequencing and unbalanced load compensation
// Summary of operation
// - Terminal with function code 62 acts as the bias hold command.
// - Hold command freezes the reference bias; release resumes tracking.
// - Run start ramps bias from zero at 100 % per startup time, then tracks.
// - End time zero disables the end ramp; otherwise sets ramp time.
// - Speed control shutdown ramps held reference torque to zero first.
// - Torque control decays total bias after holding time from start.
// - Holding time is raised to estimation time when shorter.
// - Bias magnitude clamped to the limit after gain is applied.
// - PI bias uses proportional gain and integral time.
// - Driving side and braking side gains scale the bias.
// - Three signed digital bias settings, forward torque positive.
// - Compensation enable bit turns unbalance compensation off or on.
// - Estimation and timers start on start command or else on run.
// - Start command before run means no compensation for that run.
// - In speed control, nonzero reference speed ends estimation and applies compensation at once.
// - Speed control holds zero speed, then latches torque as bias.
// - User bias alone before start; then user bias plus compensation.
// - Torque control adds compensation, decaying after holding time.
// - Source select: zero analog, one digital, two PI.
// - Digital select: off/off 1, a only 2, b only zero, both 3.
`timescale 1ns/10ps
module tbuc_top #(
    parameter int TICK_CYCLES = tbuc_pkg::TICK_CYCLES,
    parameter int NUM_TERM = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    input wire logic [4:0] regAddr,
    input wire logic [15:0] regWrData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regRdData,
    // Host terminals
    input wire logic fwdRunPin,
    input wire logic revRunPin,
    input wire logic [NUM_TERM-1:0] termPin,
    // Regulator side
    input wire logic signed [15:0] analogBias,
    input wire logic signed [15:0] torqueSensor,
    input wire logic signed [15:0] internalRefTorque,
    input wire logic signed [15:0] preRampSpeed,
    // Results
    output logic signed [15:0] torqueBias,
    output logic signed [15:0] refTorqueEnd,
    output logic zeroSpeedHold,
    output logic driveEnable
);
    localparam int STEP_DIV = TICK_CYCLES / tbuc_pkg::PCT_FULL;
    localparam logic signed [31:0] FULL_S = 32'(tbuc_pkg::PCT_FULL);
    localparam logic signed [31:0] MAX_S = 32'(tbuc_pkg::PCT_MAX);
    localparam logic signed [31:0] PONE_S = 32'(tbuc_pkg::PGAIN_ONE);
    localparam logic [31:0] TICK_LAST = 32'(TICK_CYCLES - 1);

    // One unit toward a target
    function automatic logic signed [15:0] stepToward(input logic signed [15:0] v,
                                                      input logic signed [15:0] t);
        stepToward = (v < t) ? v + 16'sh0001 : ((v > t) ? v - 16'sh0001 : v);
    endfunction

    // Saturate to the widest bias
    function automatic logic signed [15:0] sat16(input logic signed [31:0] v);
        sat16 = (v > MAX_S) ? 16'(MAX_S) : ((v < -MAX_S) ? 16'(-MAX_S) : 16'(v));
    endfunction

    logic [1:0] rstSync;
    logic rstN;
    logic [NUM_TERM+1:0] pinMeta, pinSync;
    logic [7:0] termFunc [NUM_TERM];
    logic [15:0] ctrl, startTime, endTime, biasLimit, pGain, iTime;
    logic signed [15:0] driveGain, brakeGain, digBias1, digBias2, digBias3;
    logic [15:0] estTime, holdTime;
    logic runPrev, unblPrev, shutting, rampDone;
    logic [31:0] tickCnt, startCnt, endCnt;
    logic signed [31:0] piAcc;
    logic signed [15:0] refBias, comp, decayVal, endTorque;
    logic [15:0] estCnt, holdCnt;
    tbuc_pkg::tbuc_state_type state, next_state;

    // Reset release, two stages
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) rstSync <= 2'h0;
        else rstSync <= {rstSync[0], 1'b1};
    end
    assign rstN = rstSync[1];

    // Host pins cross in through two flops
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            pinMeta <= '0;
            pinSync <= '0;
        end else begin
            pinMeta <= {fwdRunPin, revRunPin, termPin};
            pinSync <= pinMeta;
        end
    end

    // Terminal function decode
    logic [NUM_TERM-1:0] holdHit, unblHit, unblSet, selAHit, selBHit;
    genvar gi;
    generate
        for (gi = 0; gi < NUM_TERM; gi++) begin : g_term
            assign holdHit[gi] = pinSync[gi] && termFunc[gi] == tbuc_pkg::FN_HOLD;
            assign unblSet[gi] = termFunc[gi] == tbuc_pkg::FN_UNBALANCE_START_CMD;
            assign unblHit[gi] = pinSync[gi] && unblSet[gi];
            assign selAHit[gi] = pinSync[gi] && termFunc[gi] == tbuc_pkg::FN_SEL_A;
            assign selBHit[gi] = pinSync[gi] && termFunc[gi] == tbuc_pkg::FN_SEL_B;
        end
    endgenerate

    wire holdCmd = |holdHit;
    wire unblCmd = |unblHit;
    wire unblCfg = |unblSet;
    wire selA = |selAHit;
    wire selB = |selBHit;
    wire fwdCmd = pinSync[NUM_TERM+1];
    wire runCmd = fwdCmd | pinSync[NUM_TERM];
    wire runRise = runCmd && !runPrev;
    wire runFall = !runCmd && runPrev;
    wire unblRise = unblCmd && !unblPrev;
    wire ucEnable = ctrl[tbuc_pkg::CTRL_UC_BIT];
    wire torqueMode = ctrl[tbuc_pkg::CTRL_TQ_BIT];
    wire [1:0] srcSel = ctrl[tbuc_pkg::CTRL_SRC_LSB +: 2];

    // Tick and ramp step strobes; ramp moves one unit per step
    wire tick = tickCnt == TICK_LAST;
    wire [31:0] startPeriod = 32'(startTime) * 32'(STEP_DIV);
    wire [31:0] endPeriod = 32'(endTime) * 32'(STEP_DIV);
    wire startStep = startCnt + 32'h1 >= startPeriod;
    wire endStep = endCnt + 32'h1 >= endPeriod;

    // Bias source selection
    wire signed [15:0] digBias = selA ? (selB ? digBias3 : digBias2)
                                      : (selB ? 16'sh0000 : digBias1);
    wire signed [31:0] piErr = -32'(torqueSensor);
    wire signed [31:0] piInt = (iTime == 16'h0) ? 32'sh0 : piAcc / $signed({16'h0, iTime});
    wire signed [31:0] piProd = (piErr + piInt) * $signed({16'h0, pGain});
    wire signed [15:0] piBias = sat16(piProd / PONE_S);
    wire signed [15:0] rawBias = (srcSel == tbuc_pkg::SRC_DIGITAL) ? digBias :
                                 (srcSel == tbuc_pkg::SRC_PI) ? piBias :
                                 (srcSel == tbuc_pkg::SRC_ANALOG) ? analogBias : 16'sh0000;

    // Gain by side, then magnitude limit
    wire driving = fwdCmd ? !rawBias[15] : rawBias[15];
    wire signed [15:0] sideGain = driving ? driveGain : brakeGain;
    wire signed [31:0] scaled = (rawBias * sideGain) / FULL_S;
    wire signed [31:0] limS = $signed({16'h0, biasLimit});
    wire signed [15:0] selBias = (scaled > limS) ? 16'(limS) :
                                 ((scaled < -limS) ? 16'(-limS) : 16'(scaled));

    // Effective holding time never below estimation time
    wire [15:0] holdEff = (estTime > holdTime) ? estTime : holdTime;
    wire estDone = estCnt >= estTime || (!torqueMode && preRampSpeed != 16'sh0000);
    wire signed [15:0] userPlusComp = refBias + comp;

    // Register writes
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            ctrl <= 16'h0;
            startTime <= 16'h0;
            endTime <= 16'h0;
            biasLimit <= tbuc_pkg::RST_LIMIT;
            pGain <= tbuc_pkg::RST_PGAIN;
            iTime <= 16'h0;
            driveGain <= tbuc_pkg::RST_GAIN;
            brakeGain <= tbuc_pkg::RST_GAIN;
            digBias1 <= 16'sh0000;
            digBias2 <= 16'sh0000;
            digBias3 <= 16'sh0000;
            estTime <= tbuc_pkg::RST_EST;
            holdTime <= tbuc_pkg::RST_HOLD;
            for (int i = 0; i < NUM_TERM; i++) termFunc[i] <= 8'h00;
        end else if (regWrite) begin
            unique case (regAddr)
                tbuc_pkg::A_CTRL: ctrl <= regWrData;
                tbuc_pkg::A_START: startTime <= regWrData;
                tbuc_pkg::A_END: endTime <= regWrData;
                tbuc_pkg::A_LIMIT: biasLimit <= regWrData;
                tbuc_pkg::A_PGAIN: pGain <= regWrData;
                tbuc_pkg::A_ITIME: iTime <= regWrData;
                tbuc_pkg::A_DGAIN: driveGain <= regWrData;
                tbuc_pkg::A_BGAIN: brakeGain <= regWrData;
                tbuc_pkg::A_DIG1: digBias1 <= regWrData;
                tbuc_pkg::A_DIG2: digBias2 <= regWrData;
                tbuc_pkg::A_DIG3: digBias3 <= regWrData;
                tbuc_pkg::A_EST: estTime <= regWrData;
                tbuc_pkg::A_HOLD: holdTime <= regWrData;
                default: begin
                    for (int i = 0; i < NUM_TERM; i++) begin
                        if (regAddr == tbuc_pkg::A_TERM + 5'(i)) termFunc[i] <= regWrData[7:0];
                    end
                end
            endcase
        end
    end

    // Read mux; unmapped words read zero
    logic [15:0] rdMux;
    always_comb begin
        rdMux = 16'h0;
        unique case (regAddr)
            tbuc_pkg::A_CTRL: rdMux = ctrl;
            tbuc_pkg::A_START: rdMux = startTime;
            tbuc_pkg::A_END: rdMux = endTime;
            tbuc_pkg::A_LIMIT: rdMux = biasLimit;
            tbuc_pkg::A_PGAIN: rdMux = pGain;
            tbuc_pkg::A_ITIME: rdMux = iTime;
            tbuc_pkg::A_DGAIN: rdMux = driveGain;
            tbuc_pkg::A_BGAIN: rdMux = brakeGain;
            tbuc_pkg::A_DIG1: rdMux = digBias1;
            tbuc_pkg::A_DIG2: rdMux = digBias2;
            tbuc_pkg::A_DIG3: rdMux = digBias3;
            tbuc_pkg::A_EST: rdMux = estTime;
            tbuc_pkg::A_HOLD: rdMux = holdTime;
            tbuc_pkg::A_STATUS: rdMux = {8'h0, 1'b0, 3'(state), holdCmd, rampDone, shutting,
                                         runCmd};
            tbuc_pkg::A_BIAS: rdMux = torqueBias;
            tbuc_pkg::A_COMP: rdMux = comp;
            default: begin
                for (int i = 0; i < NUM_TERM; i++) begin
                    if (regAddr == tbuc_pkg::A_TERM + 5'(i)) rdMux = {8'h0, termFunc[i]};
                end
            end
        endcase
    end

    // Read data valid only the cycle after the strobe
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) regRdData <= 16'h0;
        else regRdData <= regRead ? rdMux : 16'h0;
    end

    // Tick and step counters
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            tickCnt <= 32'h0;
            startCnt <= 32'h0;
            endCnt <= 32'h0;
        end else begin
            tickCnt <= tick ? 32'h0 : tickCnt + 32'h1;
            startCnt <= startStep ? 32'h0 : startCnt + 32'h1;
            endCnt <= endStep ? 32'h0 : endCnt + 32'h1;
        end
    end

    // PI integrator runs only while a run command stands
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) piAcc <= 32'sh0;
        else if (!runCmd || srcSel != tbuc_pkg::SRC_PI) piAcc <= 32'sh0;
        else if (tick && !holdCmd) piAcc <= 32'(sat16(piAcc + piErr));
    end

    // Startup ramp and hold of the reference bias
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            refBias <= 16'sh0000;
            rampDone <= 1'b0;
            runPrev <= 1'b0;
            unblPrev <= 1'b0;
        end else begin
            runPrev <= runCmd;
            unblPrev <= unblCmd;
            if (!runCmd || runRise) begin
                refBias <= 16'sh0000;
                rampDone <= 1'b0;
            end else if (holdCmd) begin
                refBias <= refBias;
            end else if (rampDone || startTime == 16'h0 || refBias == selBias) begin
                refBias <= selBias;
                rampDone <= 1'b1;
            end else if (startStep) begin
                refBias <= stepToward(refBias, selBias);
            end
        end
    end

    // Unbalance compensation sequence
    always_comb begin
        next_state = state;
        unique case (state)
            tbuc_pkg::UC_IDLE: begin
                if (runRise && ucEnable) begin
                    if (!unblCfg) next_state = tbuc_pkg::UC_EST;
                    else if (unblCmd) next_state = tbuc_pkg::UC_OFF;
                    else next_state = tbuc_pkg::UC_WAIT;
                end
            end
            tbuc_pkg::UC_WAIT: if (unblRise) next_state = tbuc_pkg::UC_EST;
            tbuc_pkg::UC_EST: if (estDone) next_state = tbuc_pkg::UC_COMP;
            tbuc_pkg::UC_COMP: begin
                if (torqueMode && holdCnt >= holdEff) next_state = tbuc_pkg::UC_DECAY;
            end
            tbuc_pkg::UC_DECAY: next_state = state;
            tbuc_pkg::UC_OFF: next_state = state;
        endcase
        if (!runCmd) next_state = tbuc_pkg::UC_IDLE;
    end

    // Timers, compensation latch and torque control decay
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            state <= tbuc_pkg::UC_IDLE;
            estCnt <= 16'h0;
            holdCnt <= 16'h0;
            comp <= 16'sh0000;
            decayVal <= 16'sh0000;
        end else begin
            state <= next_state;
            if (state != tbuc_pkg::UC_EST && next_state == tbuc_pkg::UC_EST) begin
                estCnt <= 16'h0;
                holdCnt <= 16'h0;
            end else if (tick) begin
                estCnt <= (estCnt == 16'hffff) ? estCnt : estCnt + 16'h1;
                holdCnt <= (holdCnt == 16'hffff) ? holdCnt : holdCnt + 16'h1;
            end
            if (next_state == tbuc_pkg::UC_IDLE) comp <= 16'sh0000;
            // Against the set bias, not the ramp, so a cut estimation still totals the load
            else if (state == tbuc_pkg::UC_EST && estDone) begin
                comp <= internalRefTorque - selBias;
            end
            if (state == tbuc_pkg::UC_COMP && next_state == tbuc_pkg::UC_DECAY) begin
                decayVal <= (endTime == 16'h0) ? 16'sh0000 : userPlusComp;
            end else if (state == tbuc_pkg::UC_DECAY && endStep) begin
                decayVal <= stepToward(decayVal, 16'sh0000);
            end
        end
    end

    // Speed control end ramp of the held reference torque
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            shutting <= 1'b0;
            endTorque <= 16'sh0000;
        end else if (runFall && !torqueMode) begin
            shutting <= endTime != 16'h0;
            endTorque <= (endTime == 16'h0) ? 16'sh0000 : internalRefTorque;
        end else if (runCmd || endTorque == 16'sh0000) begin
            shutting <= 1'b0;
            endTorque <= 16'sh0000;
        end else if (shutting && endStep) begin
            endTorque <= stepToward(endTorque, 16'sh0000);
        end
    end

    // Registered outputs; zero speed hold covers the estimation window in speed control only
    always_ff @(posedge mclk or negedge rstN) begin
        if (!rstN) begin
            torqueBias <= 16'sh0000;
            refTorqueEnd <= 16'sh0000;
            zeroSpeedHold <= 1'b0;
            driveEnable <= 1'b0;
        end else begin
            torqueBias <= (state == tbuc_pkg::UC_DECAY) ? decayVal : userPlusComp;
            refTorqueEnd <= endTorque;
            zeroSpeedHold <= state == tbuc_pkg::UC_EST && !torqueMode;
            driveEnable <= runCmd || shutting;
        end
    end

    property p_hold_freeze;
        @(posedge mclk) disable iff (!rstN)
        $past(holdCmd) && $past(runCmd) && $past(runCmd, 2) |-> refBias == $past(refBias);
    endproperty
    a_hold_freeze: assert property (p_hold_freeze) else $error("bias moved under hold");

    property p_ramp_track;
        @(posedge mclk) disable iff (!rstN)
        rampDone && runCmd && runPrev && !holdCmd |=> refBias == $past(selBias);
    endproperty
    a_ramp_track: assert property (p_ramp_track) else $error("bias not tracking");

    property p_limit;
        @(posedge mclk) disable iff (!rstN)
        selBias <= $signed({1'b0, biasLimit}) && selBias >= -$signed({1'b0, biasLimit});
    endproperty
    a_limit: assert property (p_limit) else $error("bias above limit");

    property p_dig_zero;
        @(posedge mclk) disable iff (!rstN)
        srcSel == tbuc_pkg::SRC_DIGITAL && !selA && selB |-> rawBias == 16'sh0000;
    endproperty
    a_dig_zero: assert property (p_dig_zero) else $error("b only not zero");

    property p_early_start;
        @(posedge mclk) disable iff (!rstN)
        runRise && ucEnable && unblCfg && unblCmd |=> state == tbuc_pkg::UC_OFF ##1
        comp == 16'sh0000;
    endproperty
    a_early_start: assert property (p_early_start) else $error("early start compensated");

    property p_uc_disabled;
        @(posedge mclk) disable iff (!rstN)
        runRise && !ucEnable |=> state == tbuc_pkg::UC_IDLE;
    endproperty
    a_uc_disabled: assert property (p_uc_disabled) else $error("disabled but estimating");

    property p_hold_eff;
        @(posedge mclk) disable iff (!rstN)
        holdEff >= estTime && holdEff >= holdTime;
    endproperty
    a_hold_eff: assert property (p_hold_eff) else $error("holding below estimation");

    property p_speed_cut;
        @(posedge mclk) disable iff (!rstN)
        state == tbuc_pkg::UC_EST && runCmd && !torqueMode && preRampSpeed != 16'sh0000
        |=> state == tbuc_pkg::UC_COMP ##1 !zeroSpeedHold;
    endproperty
    a_speed_cut: assert property (p_speed_cut) else $error("estimation not cut");

    property p_zero_hold;
        @(posedge mclk) disable iff (!rstN)
        state == tbuc_pkg::UC_EST && !torqueMode |=> zeroSpeedHold;
    endproperty
    a_zero_hold: assert property (p_zero_hold) else $error("no zero speed hold");

    property p_end_off;
        @(posedge mclk) disable iff (!rstN)
        runFall && !torqueMode && endTime == 16'h0 |=> endTorque == 16'sh0000 && !shutting;
    endproperty
    a_end_off: assert property (p_end_off) else $error("end ramp not disabled");
endmodule

// ==== tb/tbuc_host_model.sv ====
// Host controller model driving run and terminal pins
`timescale 1ns/10ps
module tbuc_host_model (
    // Clock
    input wire logic mclk,
    // Requests from the bench, and zero speed hold from the drive
    input wire logic fwdReq,
    input wire logic holdReq,
    input wire logic unblReq,
    input wire logic early,
    input wire logic [1:0] selReq,
    input wire logic signed [15:0] speedReq,
    input wire logic zeroSpeedHold,
    // Pins toward the drive
    output logic fwdRunPin,
    output logic [7:0] termPin,
    output logic signed [15:0] preRampSpeed
);
    // Hold only after run, so a PI integrator never starts frozen
    always_ff @(posedge mclk) begin
        fwdRunPin <= fwdReq;
        termPin <= {4'h0, unblReq, holdReq & fwdReq & fwdRunPin, selReq};
        preRampSpeed <= (zeroSpeedHold & ~early) ? 16'sh0000 : speedReq;
    end
endmodule

// ==== tb/tbuc_top_tb.sv ====
// Self-checking bench for the torque bias block
`timescale 1ns/10ps
module tbuc_top_tb;
    logic mclk = 0, reset_n = 0, regWrite = 0, regRead = 0, fwdReq = 0, holdReq = 0;
    logic unblReq = 0, early = 0, zeroSpeedHold, driveEnable, fwdRunPin, revRun = 0;
    logic [1:0] selReq = 0;
    logic [4:0] regAddr = 0;
    logic [7:0] termPin;
    logic [15:0] regWrData = 0, regRdData, rdv;
    logic signed [15:0] analogBias = 0, refTorque = 0, speedReq = 0, preRampSpeed, sensor = 0;
    logic signed [15:0] torqueBias, refTorqueEnd, lim;
    logic signed [15:0] dig [3];
    int miscompares = 0, checked = 0;
    // Clock
    initial forever #2.5 mclk = ~mclk;
    // Tick shortened so timers run in a few thousand cycles
    tbuc_top #(.TICK_CYCLES(1000)) uut (.mclk(mclk), .reset_n(reset_n), .regAddr(regAddr),
        .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
        .fwdRunPin(fwdRunPin), .revRunPin(revRun), .termPin(termPin), .analogBias(analogBias),
        .torqueSensor(sensor), .internalRefTorque(refTorque), .preRampSpeed(preRampSpeed),
        .torqueBias(torqueBias), .refTorqueEnd(refTorqueEnd), .zeroSpeedHold(zeroSpeedHold),
        .driveEnable(driveEnable));
    tbuc_host_model host (.mclk(mclk), .fwdReq(fwdReq), .holdReq(holdReq), .unblReq(unblReq),
        .early(early), .selReq(selReq), .speedReq(speedReq), .zeroSpeedHold(zeroSpeedHold),
        .fwdRunPin(fwdRunPin), .termPin(termPin), .preRampSpeed(preRampSpeed));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge mclk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask
    // Read data stands only in the cycle after the strobe
    task automatic rd(input logic [4:0] a);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        @(negedge mclk);
        rdv = regRdData;
    endtask
    // Digital table then magnitude clamp; unity gains on both sides
    function automatic logic signed [15:0] selBias(input logic [1:0] s);
        logic signed [15:0] v;
        v = (s == 2'h2) ? 16'sh0000 : dig[(s == 2'h3) ? 2 : s];
        return (v > lim) ? lim : (v < -lim) ? -lim : v;
    endfunction
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // Watchdog well beyond the expected run length
    initial begin
        #300000;
        miscompares++;
        conclude();
    end
    initial begin
        void'($urandom(36));
        lim = 16'sd2000;
        cyc(16);
        reset_n <= 1'b1;
        cyc(4);
        rd(tbuc_pkg::A_LIMIT);
        chk(rdv, tbuc_pkg::RST_LIMIT);
        rd(tbuc_pkg::A_EST);
        chk(rdv, tbuc_pkg::RST_EST);
        rd(5'h1f);
        chk(rdv, 16'h0000);
        for (int i = 0; i < 4; i++) wr(tbuc_pkg::A_TERM + 5'(i), {8'h00, 8'h3c + 8'(i)});
        for (int i = 0; i < 3; i++) begin
            dig[i] = 16'($urandom % 4001) - 16'sd2000;
            wr(tbuc_pkg::A_DIG1 + 5'(i), dig[i]);
        end
        wr(tbuc_pkg::A_CTRL, 16'h0004);
        fwdReq <= 1'b1;
        for (int s = 0; s < 4; s++) begin
            selReq <= 2'(s);
            cyc(10);
            chk(torqueBias, selBias(2'(s)));
        end
        selReq <= 2'h0;
        cyc(10);
        holdReq <= 1'b1;
        cyc(10);
        selReq <= 2'h3;
        cyc(10);
        chk(torqueBias, selBias(2'h0));
        holdReq <= 1'b0;
        cyc(10);
        chk(torqueBias, selBias(2'h3));
        lim = 16'sd500;
        wr(tbuc_pkg::A_LIMIT, 16'd500);
        wr(tbuc_pkg::A_DIG3, 16'hfa24);
        dig[2] = 16'shfa24;
        cyc(10);
        chk(torqueBias, selBias(2'h3));
        analogBias <= 16'($urandom % 801) - 16'sd400;
        wr(tbuc_pkg::A_CTRL, 16'h0000);
        cyc(10);
        chk(torqueBias, analogBias);
        $display("bias select done");
        refTorque <= 16'sd300;
        wr(tbuc_pkg::A_END, 16'd5);
        fwdReq <= 1'b0;
        cyc(20);
        chk({15'h0, driveEnable && refTorqueEnd > 0}, 16'h0001);
        cyc(1600);
        chk({driveEnable, refTorqueEnd[14:0]}, 16'h0000);
        wr(tbuc_pkg::A_END, 16'd0);
        fwdReq <= 1'b1;
        cyc(20);
        fwdReq <= 1'b0;
        cyc(20);
        chk({15'h0, driveEnable}, 16'h0000);
        $display("end ramp done");
        wr(tbuc_pkg::A_CTRL, 16'h0004);
        wr(tbuc_pkg::A_START, 16'd10);
        wr(tbuc_pkg::A_DIG1, 16'd200);
        dig[0] = 16'sd200;
        selReq <= 2'h0;
        fwdReq <= 1'b1;
        cyc(500);
        chk({15'h0, torqueBias > 0 && torqueBias < 200}, 16'h0001);
        cyc(2000);
        chk(torqueBias, selBias(2'h0));
        fwdReq <= 1'b0;
        $display("startup ramp done");
        wr(tbuc_pkg::A_TERM + 5'h3, 16'h0000);
        wr(tbuc_pkg::A_LIMIT, 16'd2000);
        wr(tbuc_pkg::A_START, 16'h0000);
        wr(tbuc_pkg::A_EST, 16'd3);
        wr(tbuc_pkg::A_CTRL, 16'h0005);
        refTorque <= 16'sd400;
        fwdReq <= 1'b1;
        cyc(20);
        chk({15'h0, zeroSpeedHold}, 16'h0001);
        cyc(3100);
        chk({15'h0, zeroSpeedHold}, 16'h0000);
        chk(torqueBias, 16'sd400);
        fwdReq <= 1'b0;
        cyc(40);
        early <= 1'b1;
        speedReq <= 16'sd100;
        fwdReq <= 1'b1;
        cyc(30);
        chk({zeroSpeedHold, torqueBias[14:0]}, 16'd400);
        fwdReq <= 1'b0;
        early <= 1'b0;
        wr(tbuc_pkg::A_TERM + 5'h3, 16'h0043);
        unblReq <= 1'b1;
        cyc(40);
        fwdReq <= 1'b1;
        cyc(20);
        rd(tbuc_pkg::A_STATUS);
        chk({13'h0, rdv[6:4]}, 16'h0005);
        $display("unbalance done");
        // Torque control: user bias alone through estimation after the start terminal, then decay to zero
        fwdReq <= 1'b0;
        unblReq <= 1'b0;
        wr(tbuc_pkg::A_CTRL, 16'h0007);
        wr(tbuc_pkg::A_END, 16'h0002);
        wr(tbuc_pkg::A_HOLD, 16'h0001);
        fwdReq <= 1'b1;
        cyc(20);
        unblReq <= 1'b1;
        cyc(1500);
        chk({zeroSpeedHold, torqueBias[14:0]}, 16'h00c8);
        cyc(2500);
        chk(torqueBias, 16'sh0000);
        rd(tbuc_pkg::A_STATUS);
        chk({13'h0, rdv[6:4]}, 16'h0004);
        fwdReq <= 1'b0;
        unblReq <= 1'b0;
        $display("torque control done");
        // PI source under reverse run; no integral term, unit proportional gain
        wr(tbuc_pkg::A_CTRL, 16'h0008);
        sensor <= 16'($urandom % 801) - 16'sh0190;
        revRun <= 1'b1;
        cyc(20);
        chk(torqueBias, -sensor);
        revRun <= 1'b0;
        $display("pi bias done");
        conclude();
    end
endmodule
